// *** lmr_readout.sv ***
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "lmr_cfg.svh"

// Overview of operation
// (RL1) Power result shows selected transistor's live power
// (RL2) Pointer codes 000..101 select Q1..Q6
// (RL3) Q1,Q2,Q5,Q6 power saturates at 0xFF full scale
// (RL4) Q3,Q4 power saturates at 0xFF full scale
// (RL5) Loop voltage bit6 polarity, bit7 zero
// (RL6) Loop voltage bits5:0 unsigned magnitude, clamped
// (RL7) Loop current bit6 direction, bit7 zero
// (RL8) Loop current bits5:0 unsigned magnitude, clamped
// (RL9) Tip register holds live tip voltage count
// (RL10) Ring register holds live ring voltage count
// (RL11) Two battery registers hold same battery count
// (RL12) First-transistor current register holds live count
// (RL13) Extended feed enabled removes extended feed current
// (RL14) Sense writes ignored; reads give latest sample
// (RL15) Sense registers read zero until first sample
module lmr_readout (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire lmr_pkg::lmr_addr_t paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic meas_valid_i,
    input wire logic [5:0][8:0] meas_power_i,
    input wire logic signed [7:0] meas_loop_v_i,
    input wire logic signed [7:0] meas_loop_i_i,
    input wire logic [7:0] meas_tip_i,
    input wire logic [7:0] meas_ring_i,
    input wire logic [7:0] meas_bat_i,
    input wire logic [7:0] meas_q1_cur_i,
    input wire logic [7:0] meas_ext_feed_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic ext_feed_en_o
);
    import lmr_pkg::*;

    // Registered state and its next value
    lmr_state_s s;
    lmr_state_s next_s;
    // Power codes after saturation, one per transistor
    logic [5:0][7:0] pwr_sat;

    // Register index from a byte address
    function automatic lmr_byte_t lmr_index(input lmr_addr_t a);
        return a[9:2];
    endfunction

    // Aligned, in range and naming a register of this block
    function automatic logic lmr_mapped(input lmr_addr_t a);
        logic hit;
        hit = 1'b0;
        if (a[1:0] == 2'b00 && a[11:10] == 2'b00) begin
            case (lmr_index(a))
                `LMR_IDX_PTR, `LMR_IDX_PWR, `LMR_IDX_LV, `LMR_IDX_LC,
                `LMR_IDX_TIP, `LMR_IDX_RING, `LMR_IDX_BATA, `LMR_IDX_BATB,
                `LMR_IDX_Q1CUR, `LMR_IDX_CTRL: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    // Clamp a signed reading to sign bit plus six-bit magnitude
    function automatic lmr_byte_t lmr_sign_mag(input logic signed [7:0] v);
        logic [7:0] mag;
        logic neg;
        neg = v[7];
        mag = neg ? 8'(-v) : 8'(v);
        // Most negative input has a magnitude of 128; clamp it too
        if (neg && v == 8'sh80) begin
            mag = 8'hFF;
        end
        if (mag > {2'b00, `LMR_MAG_MAX}) begin
            mag = {2'b00, `LMR_MAG_MAX};
        end
        return {1'b0, neg, mag[`LMR_MAG_MSB:0]};
    endfunction

    // Power of whichever transistor the pointer names
    function automatic lmr_byte_t lmr_power_sel(input lmr_state_s st);
        lmr_byte_t val;
        case (st.ptr)
            LMR_Q1: val = st.pwr[0];
            LMR_Q2: val = st.pwr[1];
            LMR_Q3: val = st.pwr[2];
            LMR_Q4: val = st.pwr[3];
            LMR_Q5: val = st.pwr[4];
            LMR_Q6: val = st.pwr[5];
            // Undefined codes read a quiet zero
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // Read multiplexer
    function automatic logic [31:0] lmr_read(input lmr_state_s st, input lmr_addr_t a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (lmr_index(a))
            `LMR_IDX_PTR: d = {29'h0, st.ptr};
            `LMR_IDX_PWR: d = {24'h0, lmr_power_sel(st)}; // [RL1]
            `LMR_IDX_LV: d = {24'h0, st.lv};
            `LMR_IDX_LC: d = {24'h0, st.lc};
            `LMR_IDX_TIP: d = {24'h0, st.tip};
            `LMR_IDX_RING: d = {24'h0, st.ring};
            `LMR_IDX_BATA: d = {24'h0, st.bata};
            `LMR_IDX_BATB: d = {24'h0, st.batb};
            `LMR_IDX_Q1CUR: d = {24'h0, st.q1_cur};
            `LMR_IDX_CTRL: d = {31'h0, st.ext_en};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Saturate each transistor's raw power; both scale groups top out at 0xFF
    generate
        for (genvar q = 0; q < 6; q++) begin : g_pwr
            always_comb begin
                if (meas_power_i[q] > {1'b0, `LMR_CNT_MAX}) begin
                    pwr_sat[q] = `LMR_CNT_MAX; // [RL3] [RL4]
                end else begin
                    pwr_sat[q] = meas_power_i[q][7:0];
                end
            end
        end
    endgenerate

    // Next-state logic: sample capture and the bus slave
    always_comb begin
        next_s = s;
        // Whole sample latched together so a read never mixes two samples
        if (meas_valid_i) begin
            next_s.seen = 1'b1;
            next_s.pwr = pwr_sat;
            next_s.lv = lmr_sign_mag(meas_loop_v_i); // [RL5] [RL6]
            next_s.lc = lmr_sign_mag(meas_loop_i_i); // [RL7] [RL8]
            next_s.tip = meas_tip_i; // [RL9]
            next_s.ring = meas_ring_i; // [RL10]
            next_s.bata = meas_bat_i; // [RL11]
            next_s.batb = meas_bat_i; // [RL11]
            // Floor at zero so a noisy extended-feed reading cannot wrap
            if (s.ext_en) begin
                if (meas_q1_cur_i > meas_ext_feed_i) begin
                    next_s.q1_cur = meas_q1_cur_i - meas_ext_feed_i; // [RL13]
                end else begin
                    next_s.q1_cur = 8'h00; // [RL13]
                end
            end else begin
                next_s.q1_cur = meas_q1_cur_i; // [RL12]
            end
        end
        case (s.apb_state)
            LMR_IDLE: begin
                next_s.pready = 1'b0;
                next_s.pslverr = 1'b0;
                // Access phase seen: answer on the next cycle
                if (psel_i && penable_i) begin
                    next_s.apb_state = LMR_RESP;
                    next_s.pready = 1'b1;
                    next_s.pslverr = !lmr_mapped(paddr_i);
                    if (!pwrite_i && lmr_mapped(paddr_i)) begin
                        next_s.prdata = lmr_read(s, paddr_i); // [RL14]
                    end else begin
                        next_s.prdata = 32'h0000_0000;
                    end
                end
            end
            LMR_RESP: begin
                next_s.apb_state = LMR_IDLE;
                next_s.pready = 1'b0;
                next_s.pslverr = 1'b0;
                next_s.prdata = 32'h0000_0000;
                // Write lands on the edge where the master sees pready
                if (psel_i && penable_i && pwrite_i && !s.pslverr) begin
                    case (lmr_index(paddr_i))
                        `LMR_IDX_PTR: next_s.ptr = pwdata_i[`LMR_PTR_MSB:0]; // [RL2]
                        `LMR_IDX_CTRL: next_s.ext_en = pwdata_i[`LMR_EXT_EN_BIT];
                        // Sense registers are read-only; writes drop here
                        default: next_s.ptr = s.ptr; // [RL14]
                    endcase
                end
            end
            default: begin
                next_s.apb_state = LMR_IDLE;
                next_s.pready = 1'b0;
            end
        endcase
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
            s.ptr <= `LMR_RST_PTR;
            s.ext_en <= `LMR_RST_EXT_EN;
            s.lv <= `LMR_RST_SENSE; // [RL15]
            s.tip <= `LMR_RST_SENSE; // [RL15]
            s.ring <= `LMR_RST_SENSE; // [RL15]
            s.batb <= `LMR_RST_SENSE; // [RL15]
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o = s.prdata;
    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign ext_feed_en_o = s.ext_en;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // Read access phase to a given index, first cycle
    sequence q_rd(lmr_byte_t idx);
        ce_i && psel_i && penable_i && !pwrite_i && !s.pready
            && lmr_mapped(paddr_i) && lmr_index(paddr_i) == idx;
    endsequence

    // Write access completing to a given index
    sequence q_wr_done(lmr_byte_t idx);
        ce_i && psel_i && penable_i && pwrite_i && s.pready && !s.pslverr
            && lmr_index(paddr_i) == idx;
    endsequence

    // Power read with pointer on Q3 returns Q3 result
    property p_pwr_sel;
        q_rd(`LMR_IDX_PWR) ##0 (s.ptr == LMR_Q3) |=> prdata_o == {24'h0, s.pwr[2]};
    endproperty
    a_pwr_sel: assert property (p_pwr_sel) // [RL1]
        else $error("power read does not follow pointer");

    // Pointer write reads back as written
    property p_ptr_wr;
        q_wr_done(`LMR_IDX_PTR) |=> s.ptr == $past(pwdata_i[2:0]);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) // [RL2]
        else $error("pointer write lost");

    // Over-range power saturates
    property p_pwr_sat;
        ce_i && meas_valid_i && meas_power_i[0] > 9'h0FF |=> s.pwr[0] == 8'hFF;
    endproperty
    a_pwr_sat: assert property (p_pwr_sat) // [RL3]
        else $error("power not saturated");

    // Low-power transistor in range passes unchanged
    property p_pwr_lo;
        ce_i && meas_valid_i && meas_power_i[3] <= 9'h0FF
            |=> s.pwr[3] == $past(meas_power_i[3][7:0]);
    endproperty
    a_pwr_lo: assert property (p_pwr_lo) // [RL4]
        else $error("low-range power code altered");

    // Loop voltage read has bit 7 clear and polarity tracks sign
    property p_lv_read;
        q_rd(`LMR_IDX_LV) |=> prdata_o[31:7] == 25'h0 && prdata_o[6] == s.lv[6];
    endproperty
    a_lv_read: assert property (p_lv_read) // [RL5]
        else $error("loop voltage high bits wrong");

    // Large negative loop voltage clamps to polarity plus full magnitude
    property p_lv_clamp;
        ce_i && meas_valid_i && meas_loop_v_i < -8'sd63 |=> s.lv == 8'h7F;
    endproperty
    a_lv_clamp: assert property (p_lv_clamp) // [RL6]
        else $error("loop voltage clamp wrong");

    // Small forward loop current passes as magnitude, direction clear
    property p_lc_fwd;
        ce_i && meas_valid_i && meas_loop_i_i >= 0 && meas_loop_i_i <= 8'sd63
            |=> s.lc == $past(meas_loop_i_i);
    endproperty
    a_lc_fwd: assert property (p_lc_fwd) // [RL7]
        else $error("forward loop current wrong");

    // Battery registers agree with each other after a sample
    property p_bat_pair;
        ce_i && meas_valid_i |=> s.bata == s.batb && s.bata == $past(meas_bat_i);
    endproperty
    a_bat_pair: assert property (p_bat_pair) // [RL11]
        else $error("battery registers disagree");

    // Extended feed current removed when enabled
    property p_q1_ext;
        ce_i && meas_valid_i && s.ext_en && meas_q1_cur_i >= meas_ext_feed_i
            |=> s.q1_cur == $past(meas_q1_cur_i) - $past(meas_ext_feed_i);
    endproperty
    a_q1_ext: assert property (p_q1_ext) // [RL13]
        else $error("extended feed current not removed");

    // Without the extended feed the full first-transistor current is kept
    property p_q1_plain;
        ce_i && meas_valid_i && !s.ext_en |=> s.q1_cur == $past(meas_q1_cur_i);
    endproperty
    a_q1_plain: assert property (p_q1_plain) // [RL12]
        else $error("first transistor current not refreshed");

    // Tip register follows each sample
    property p_tip_live;
        ce_i && meas_valid_i |=> s.tip == $past(meas_tip_i);
    endproperty
    a_tip_live: assert property (p_tip_live) // [RL9]
        else $error("tip voltage not refreshed");

    // Ring register follows each sample
    property p_ring_live;
        ce_i && meas_valid_i |=> s.ring == $past(meas_ring_i);
    endproperty
    a_ring_live: assert property (p_ring_live) // [RL10]
        else $error("ring voltage not refreshed");

    // Reverse loop current sets direction; magnitude cancels the raw low bits
    property p_lc_rev;
        ce_i && meas_valid_i && meas_loop_i_i < 8'sd0 && meas_loop_i_i > -8'sd64
            |=> s.lc[7:6] == 2'b01 && s.lc[5:0] + $past(meas_loop_i_i[5:0]) == 6'h00;
    endproperty
    a_lc_rev: assert property (p_lc_rev) // [RL8]
        else $error("reverse loop current wrong");

    // Write to a sense register without a new sample leaves it alone
    property p_ro_write;
        q_wr_done(`LMR_IDX_TIP) ##0 !meas_valid_i |=> $stable(s.tip);
    endproperty
    a_ro_write: assert property (p_ro_write) // [RL14]
        else $error("sense register took a write");

    // Before the first sample the zero-reset registers stay zero
    property p_pre_sample;
        !s.seen |-> s.lv == 8'h00 && s.tip == 8'h00 && s.ring == 8'h00 && s.batb == 8'h00;
    endproperty
    a_pre_sample: assert property (p_pre_sample) // [RL15]
        else $error("sense register nonzero before first sample");

    // Every access phase is answered after one wait cycle, for one cycle
    property p_answer;
        ce_i && psel_i && penable_i && !s.pready ##1 ce_i |-> s.pready ##1 !s.pready;
    endproperty
    a_answer: assert property (p_answer) // [RL14]
        else $error("bus answer timing wrong");

endmodule

// *** lmr_cfg.svh ***
`ifndef LMR_CFG_SVH
`define LMR_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define LMR_IDX_PTR 8'h4C
`define LMR_IDX_PWR 8'h4D
`define LMR_IDX_LV 8'h4E
`define LMR_IDX_LC 8'h4F
`define LMR_IDX_TIP 8'h50
`define LMR_IDX_RING 8'h51
`define LMR_IDX_BATA 8'h52
`define LMR_IDX_BATB 8'h53
`define LMR_IDX_Q1CUR 8'h54
`define LMR_IDX_CTRL 8'h5F

// Field positions
`define LMR_POL_BIT 6
`define LMR_MAG_MSB 5
`define LMR_PTR_MSB 2
`define LMR_EXT_EN_BIT 0

// Reset values
`define LMR_RST_SENSE 8'h00
`define LMR_RST_PTR 3'h0
`define LMR_RST_EXT_EN 1'b0

// Full-scale codes
`define LMR_MAG_MAX 6'h3F
`define LMR_CNT_MAX 8'hFF

// Slave answers one cycle after the access phase starts
`define LMR_WAIT_CYCLES 1

`endif

// *** lmr_pkg.sv ***
`include "lmr_cfg.svh"

package lmr_pkg;

    // Bus handshake states
    typedef enum logic [0:0] {
        LMR_IDLE = 1'b0,
        LMR_RESP = 1'b1
    } lmr_apb_e;

    // Power pointer codes, one per external transistor
    typedef enum logic [2:0] {
        LMR_Q1 = 3'b000,
        LMR_Q2 = 3'b001,
        LMR_Q3 = 3'b010,
        LMR_Q4 = 3'b011,
        LMR_Q5 = 3'b100,
        LMR_Q6 = 3'b101
    } lmr_ptr_e;

    typedef logic [11:0] lmr_addr_t;
    typedef logic [7:0] lmr_byte_t;

    // Whole state of the readout block
    typedef struct packed {
        lmr_apb_e apb_state;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] ptr;
        logic ext_en;
        logic seen;
        logic [5:0][7:0] pwr;
        lmr_byte_t lv;
        lmr_byte_t lc;
        lmr_byte_t tip;
        lmr_byte_t ring;
        lmr_byte_t bata;
        lmr_byte_t batb;
        lmr_byte_t q1_cur;
    } lmr_state_s;

endpackage

// *** test_line_monitor_readout_regs.sv ***
`timescale 1ns/10ps
`include "lmr_cfg.svh"

module test_line_monitor_readout_regs;
    // Bench-side drive of the bus and of the measurement engine
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1; // Held high except in t_gnd, which checks that a sample offered while ce is low is not taken
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic mv = 1'b0;
    logic [5:0][8:0] m_pwr = '0;
    logic signed [7:0] m_lv = 8'sh00;
    logic signed [7:0] m_li = 8'sh00;
    logic [7:0] m_tip = 8'h00;
    logic [7:0] m_ring = 8'h00;
    logic [7:0] m_bat = 8'h00;
    logic [7:0] m_q1cur = 8'h00;
    logic [7:0] m_ext = 8'h00;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire ext_en;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd; // Data of the last transfer
    logic err; // Error flag of the last transfer

    lmr_readout dut (
        .clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .meas_valid_i(mv),
        .meas_power_i(m_pwr), .meas_loop_v_i(m_lv), .meas_loop_i_i(m_li),
        .meas_tip_i(m_tip), .meas_ring_i(m_ring), .meas_bat_i(m_bat),
        .meas_q1_cur_i(m_q1cur), .meas_ext_feed_i(m_ext), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ext_feed_en_o(ext_en)
    );

    // 100 MHz system clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Hang guard; the run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks made: %0d, mismatches: %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Byte address of a register index
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // One APB transfer; request held until the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        // Values read at the edge are those it samples; only the hang guard ends the wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Read a register and compare, expecting an OKAY answer
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, ba(idx), 32'h0000_0000);
        chk(rd, exp, $sformatf("reg %h", idx));
        chk({31'h0, err}, 32'h0000_0000, "read error");
    endtask

    // One complete sample from the measurement engine
    task automatic samp();
        @(posedge clk);
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
    endtask

    // Expected sign and magnitude encoding of a loop value
    function automatic logic [31:0] sm(input logic signed [7:0] v);
        int a;
        a = (v < 0) ? -int'(v) : int'(v);
        return {24'h0, 1'b0, v < 0, (a > 63) ? 6'h3F : 6'(a)};
    endfunction

    // Sense registers start at zero before any sample
    task automatic t_reset();
        for (int i = `LMR_IDX_PWR; i <= `LMR_IDX_Q1CUR; i++) begin
            rdchk(8'(i), 32'h0000_0000);
        end
    endtask

    // Every pointer code, with overrange raw codes saturating
    task automatic t_power();
        logic [5:0][8:0] p;
        p = {9'h0C3, 9'h055, 9'h0E7, 9'h100, 9'h0FF, 9'h1A0};
        m_pwr <= p;
        samp();
        for (int q = 0; q < 6; q++) begin
            apb(1'b1, ba(`LMR_IDX_PTR), 32'(q));
            rdchk(`LMR_IDX_PTR, 32'(q));
            rdchk(`LMR_IDX_PWR, (p[q] > 9'h0FF) ? 32'h0000_00FF : 32'(p[q]));
        end
        // Live refresh while the pointer stays on the last transistor
        m_pwr[5] <= 9'h012;
        samp();
        rdchk(`LMR_IDX_PWR, 32'h0000_0012);
        // Code 110 names no transistor and reads a quiet zero
        apb(1'b1, ba(`LMR_IDX_PTR), 32'h0000_0006);
        rdchk(`LMR_IDX_PWR, 32'h0000_0000);
    endtask

    // Polarity, zero top bit and clamped magnitudes
    task automatic t_loop();
        logic signed [7:0] tv [7];
        tv = '{8'sh0A, -8'sh05, 8'sh64, -8'sh80, 8'sh00, 8'sh3F, -8'sh40};
        foreach (tv[i]) begin
            m_lv <= tv[i];
            m_li <= ~tv[i];
            samp();
            rdchk(`LMR_IDX_LV, sm(tv[i]));
            rdchk(`LMR_IDX_LC, sm(~tv[i]));
        end
    endtask

    // Ground-referenced voltages and first transistor current
    task automatic t_gnd();
        m_tip <= 8'hFF;
        m_ring <= 8'h5A;
        m_bat <= 8'hA5;
        m_q1cur <= 8'h80;
        m_ext <= 8'h30;
        samp();
        rdchk(`LMR_IDX_TIP, 32'h0000_00FF);
        rdchk(`LMR_IDX_RING, 32'h0000_005A);
        rdchk(`LMR_IDX_BATA, 32'h0000_00A5);
        rdchk(`LMR_IDX_BATB, 32'h0000_00A5);
        rdchk(`LMR_IDX_Q1CUR, 32'h0000_0080);
        apb(1'b1, ba(`LMR_IDX_CTRL), 32'h0000_0001);
        // Enable lands on the edge that ends the transfer; look one edge later
        @(posedge clk);
        chk({31'h0, ext_en}, 32'h0000_0001, "feed enable");
        // The new setting applies from the next sample on
        samp();
        rdchk(`LMR_IDX_Q1CUR, 32'h0000_0050);
        // Share larger than the total must not wrap round
        m_ext <= 8'h90;
        samp();
        rdchk(`LMR_IDX_Q1CUR, 32'h0000_0000);
        apb(1'b1, ba(`LMR_IDX_CTRL), 32'h0000_0000);
        samp();
        rdchk(`LMR_IDX_Q1CUR, 32'h0000_0080);
        // A sample offered while the clock enable is low is not taken
        ce <= 1'b0;
        m_tip <= 8'h77;
        samp();
        ce <= 1'b1;
        rdchk(`LMR_IDX_TIP, 32'h0000_00FF);
    endtask

    // Writes to sense registers dropped; bad addresses refused
    task automatic t_wr();
        logic [7:0] ex [8];
        ex = '{8'h33, 8'h05, 8'h43, 8'h11, 8'h22, 8'h3C, 8'h3C, 8'h44};
        apb(1'b1, ba(`LMR_IDX_PTR), 32'h0000_0000);
        m_pwr[0] <= 9'h033;
        m_lv <= 8'sh05;
        m_li <= -8'sh03;
        m_tip <= 8'h11;
        m_ring <= 8'h22;
        m_bat <= 8'h3C;
        m_q1cur <= 8'h44;
        samp();
        foreach (ex[i]) begin
            apb(1'b1, ba(8'(`LMR_IDX_PWR + i)), 32'hFFFF_FFFF);
            chk({31'h0, err}, 32'h0000_0000, "write answer");
            rdchk(8'(`LMR_IDX_PWR + i), {24'h0, ex[i]});
        end
        apb(1'b1, 12'h200, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001, "unmapped write");
        apb(1'b0, 12'h135, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001, "misaligned read");
    endtask

    // Main sequence: reset for four cycles, then each scenario
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_power();
        t_loop();
        t_gnd();
        t_wr();
        wrap_up();
    end
endmodule
